// [verilog/isrc_pkg.sv]
// constants, commands and state types of the status and remote control block
`default_nettype none
package isrc_pkg;
  localparam int ERR_DEPTH    = 20;
  localparam int ERR_TEXT_MAX = 80;
  localparam int MSG_MAX      = 16;
  localparam int ID_MAX       = 39;
  localparam int RDG_MAX      = 2000;
  localparam int KEYS         = 8;
  localparam int LOCAL_KEY    = 0;
  localparam int FIFO_DEPTH   = 8;
  localparam int ESR_OPC_BIT  = 0;
  localparam int STB_EAV_BIT  = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT  = 4;
  localparam int STB_ESB_BIT  = 5;
  localparam int STB_RQS_BIT  = 6;
  localparam logic [4:0]  TALK_ONLY_ADDR = 5'h1F;
  localparam logic [7:0]  CTRL_C         = 8'h03;
  localparam logic [15:0] ERR_NONE       = 16'h0000;
  localparam logic [15:0] ERR_OVERFLOW   = 16'hFEA2;
  localparam logic [15:0] ERR_NO_STORE   = 16'hFF1A;
  localparam logic [31:0] OPC_ANSWER     = 32'h0000_0001;
  typedef enum logic [4:0] {
    C_NOP, C_CLS, C_ESE_W, C_ESE_Q, C_ESR_Q, C_OPC, C_OPC_Q, C_PSC_W,
    C_PSC_Q, C_SRE_W, C_SRE_Q, C_STB_Q, C_QEN_W, C_QEN_Q, C_QEV_Q,
    C_PRESET, C_RST, C_ERR_Q, C_LOCAL, C_REMOTE, C_TXT_CHAR, C_TXT_CLR,
    C_TXT_Q, C_ID_DEF, C_ID_COMPAT, C_ID_CHAR, C_IDN_Q, C_FETCH_Q,
    C_POINTS_Q, C_READ_Q, C_INIT, C_FEED_W
  } isrc_cmd_e;
  typedef enum logic [1:0] {
    select_default_id_string, select_compatible_id_string,
    set_custom_id_string
  } isrc_id_e;
  typedef enum logic [1:0] {TRIG_IDLE, TRIG_WAIT_MEM, TRIG_WAIT_OUT}
    isrc_trig_e;
  typedef struct packed {
    isrc_cmd_e   op;
    logic [15:0] arg;
  } isrc_cmd_s;
  typedef struct packed {
    logic        init;
    logic [7:0]  ese;
    logic [7:0]  sre;
    logic [7:0]  esr;
    logic [15:0] qev;
    logic [15:0] qen;
    logic        psc;
    logic        remote;
    logic        feed;
    isrc_id_e    id_sel;
    logic [5:0]  id_len;
    logic [4:0]  txt_len;
    isrc_trig_e  trig;
    logic        fetching;
    logic [10:0] rdg_cnt;
    logic [10:0] fetch_ptr;
    logic [4:0]  eq_rd;
    logic [4:0]  eq_wr;
    logic [4:0]  eq_cnt;
    logic        dtr;
    logic        abort;
  } isrc_state_s;
endpackage
`default_nettype wire

// [verilog/isrc_top.sv]
// status reporting, error queue and remote control core with answer fifo
//
// Function
// - error queue holds 20 entries, oldest first
// - panel message keeps 16 characters, clear removes
// - reset to defaults keeps error queue
// - operation complete sets event bit 0
// - operation complete query answers 1 after execution
// - power-on clear flag decides mask clearing
// - status query matches poll, keeps service bit
// - clear status zeroes event registers and their summary bits
// - questionable mask selects summary, reads back
// - status preset clears questionable mask
// - event and status masks writable and readable
// - register queries answer binary-weighted value
// - device clear aborts, idles, flushes buffers
// - device clear keeps status, errors, configuration
// - serial Ctrl-C acts as device clear
// - handshake output true after device clear
// - address 31 selects talk-only output
// - talk-only over serial while in local
// - remote mode ignores all keys but local
// - fetch copies stored readings, points counts them
// - read query arms trigger, readings go out
// - custom identity string up to 39 characters
// - storage holds 2000 readings, disabled fetch errors
`default_nettype none

module isrc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_flush,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } isrc_fifo_s;
  isrc_fifo_s   st;
  isrc_fifo_s   next_st;
  logic [W-1:0] mem [DEPTH];
  logic         full;
  logic         empty;
  logic         push;

  assign full    = (st.wr[AW] != st.rd[AW]) &&
                   (st.wr[AW-1:0] == st.rd[AW-1:0]);
  assign empty   = st.wr == st.rd;
  assign o_ready = !full && !i_flush;
  assign o_valid = !empty;
  assign o_data  = mem[st.rd[AW-1:0]];
  assign push    = i_valid && o_ready;

  always_comb begin
    next_st = st;
    if (i_flush) begin
      next_st.rd = st.wr;
    end else begin
      if (push) next_st.wr = st.wr + 1'b1;
      if (i_ready && !empty) next_st.rd = st.rd + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) st <= '0;
    else st <= next_st;
  end

  always_ff @(posedge i_core_clk) begin
    if (push) mem[st.wr[AW-1:0]] <= i_data;
  end
endmodule

module isrc_top (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_cmd_valid,
  input  wire isrc_pkg::isrc_cmd_s    i_cmd,
  output logic                        o_cmd_ready,
  output logic                        o_resp_valid,
  output logic [31:0]                 o_resp_data,
  input  wire logic                   i_resp_ready,
  input  wire logic                   i_rdg_valid,
  input  wire logic [31:0]            i_rdg_data,
  output logic                        o_rdg_ready,
  input  wire logic                   i_meas_done,
  output isrc_pkg::isrc_trig_e        o_trig_state,
  output logic                        o_abort,
  output logic                        o_in_flush,
  input  wire logic                   i_dev_clear,
  input  wire logic                   i_ser_valid,
  input  wire logic [7:0]             i_ser_byte,
  output logic                        o_dtr,
  input  wire logic                   i_err_valid,
  input  wire logic [15:0]            i_err_code,
  output logic                        o_err_ready,
  input  wire logic [7:0]             i_esr_event,
  input  wire logic [15:0]            i_ques_event,
  input  wire logic                   i_nv_psc,
  input  wire logic [7:0]             i_nv_ese,
  input  wire logic [7:0]             i_nv_sre,
  output logic                        o_psc,
  output logic [7:0]                  o_ese,
  output logic [7:0]                  o_sre,
  output logic [7:0]                  o_stb,
  output logic                        o_srq,
  input  wire logic [4:0]             i_bus_addr,
  input  wire logic                   i_serial_sel,
  output logic                        o_talk_only,
  output logic                        o_tx_serial,
  output logic                        o_remote,
  input  wire logic [isrc_pkg::KEYS-1:0] i_key_pin,
  output logic [isrc_pkg::KEYS-1:0]   o_key_active,
  output logic [4:0]                  o_msg_len,
  output isrc_pkg::isrc_id_e          o_id_sel
);
  isrc_pkg::isrc_state_s st;
  isrc_pkg::isrc_state_s next_st;
  logic [31:0] rdg_mem [isrc_pkg::RDG_MAX];
  logic [15:0] err_mem [isrc_pkg::ERR_DEPTH];
  logic [7:0]  txt_mem [isrc_pkg::MSG_MAX];
  logic [7:0]  id_mem  [isrc_pkg::ID_MAX];
  logic [isrc_pkg::KEYS-1:0] key_s1;
  logic [isrc_pkg::KEYS-1:0] key_s2;
  logic [isrc_pkg::KEYS-1:0] key_s3;
  logic [isrc_pkg::KEYS-1:0] key_lvl;
  logic        dev_clr;
  logic        cmd_go;
  logic        push;
  logic [31:0] push_data;
  logic        fifo_ready;
  logic        rdg_go;
  logic        eq_push;
  logic [15:0] eq_code;
  logic        eq_pop;
  logic        err_int;
  logic [7:0]  stb;
  logic        rqs;
  logic        mem_wr;
  logic        txt_wr;
  logic        id_wr;

  // pins: a level change counts once stages two and three agree
  genvar k;
  generate
    for (k = 0; k < isrc_pkg::KEYS; k++) begin : g_key
      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          key_s1[k]  <= 1'b0;
          key_s2[k]  <= 1'b0;
          key_s3[k]  <= 1'b0;
          key_lvl[k] <= 1'b0;
        end else begin
          key_s1[k] <= i_key_pin[k];
          key_s2[k] <= key_s1[k];
          key_s3[k] <= key_s2[k];
          if (key_s2[k] == key_s3[k]) key_lvl[k] <= key_s3[k];
        end
      end
      if (k == isrc_pkg::LOCAL_KEY) begin : g_local
        assign o_key_active[k] = key_lvl[k];
      end else begin : g_other
        assign o_key_active[k] = key_lvl[k] && !st.remote;
      end
    end
  endgenerate

  assign dev_clr = i_dev_clear ||
                   (i_ser_valid && i_ser_byte == isrc_pkg::CTRL_C);

  // each event register feeds one summary bit through its mask
  always_comb begin
    stb = '0;
    stb[isrc_pkg::STB_EAV_BIT]  = st.eq_cnt != '0;
    stb[isrc_pkg::STB_QUES_BIT] = |(st.qev & st.qen);
    stb[isrc_pkg::STB_MAV_BIT]  = o_resp_valid;
    stb[isrc_pkg::STB_ESB_BIT]  = |(st.esr & st.ese);
    rqs = |(stb & st.sre);
    stb[isrc_pkg::STB_RQS_BIT]  = rqs;
  end

  // fetch streaming holds off new commands
  assign o_cmd_ready = !st.init && !st.fetching && fifo_ready && !dev_clr;
  assign cmd_go      = i_cmd_valid && o_cmd_ready;
  assign rdg_go      = i_rdg_valid && o_rdg_ready;
  assign mem_wr      = rdg_go && st.trig == isrc_pkg::TRIG_WAIT_MEM &&
                       st.rdg_cnt < 11'(isrc_pkg::RDG_MAX);
  assign txt_wr      = cmd_go && i_cmd.op == isrc_pkg::C_TXT_CHAR &&
                       st.txt_len < 5'(isrc_pkg::MSG_MAX);
  assign id_wr       = cmd_go && i_cmd.op == isrc_pkg::C_ID_CHAR &&
                       st.id_len < 6'(isrc_pkg::ID_MAX);
  assign err_int     = cmd_go && i_cmd.op == isrc_pkg::C_FETCH_Q &&
                       !st.feed;
  assign o_err_ready = !st.init && !err_int;
  assign eq_push     = err_int || (i_err_valid && o_err_ready);
  assign eq_pop      = cmd_go && i_cmd.op == isrc_pkg::C_ERR_Q &&
                       st.eq_cnt != '0;

  // full queue: drop the new error and, unless a read pops, turn the newest into overflow
  always_comb begin
    eq_code = err_int ? isrc_pkg::ERR_NO_STORE : i_err_code;
    if (st.eq_cnt == 5'(isrc_pkg::ERR_DEPTH) && !eq_pop)
      eq_code = isrc_pkg::ERR_OVERFLOW;
  end

  // readings go straight out when armed for output or in talk-only, except while storing
  always_comb begin
    o_rdg_ready = 1'b0;
    if (st.trig == isrc_pkg::TRIG_WAIT_MEM) o_rdg_ready = !dev_clr;
    else if (st.trig == isrc_pkg::TRIG_WAIT_OUT || o_talk_only)
      o_rdg_ready = fifo_ready && !i_cmd_valid && !st.fetching &&
                    !dev_clr;
  end

  always_comb begin
    next_st   = st;
    push      = 1'b0;
    push_data = '0;
    next_st.abort = 1'b0;
    next_st.dtr   = fifo_ready || st.dtr;
    if (st.init) begin
      next_st.init = 1'b0;
      next_st.psc  = i_nv_psc;
      next_st.ese  = i_nv_psc ? 8'h00 : i_nv_ese;
      next_st.sre  = i_nv_psc ? 8'h00 : i_nv_sre;
    end
    if (eq_push && st.eq_cnt != 5'(isrc_pkg::ERR_DEPTH)) begin
      next_st.eq_wr = (st.eq_wr == 5'(isrc_pkg::ERR_DEPTH - 1)) ?
                      5'h00 : st.eq_wr + 5'h01;
      next_st.eq_cnt = st.eq_cnt + 5'h01;
    end
    if (eq_pop) begin
      push_data = 32'(err_mem[st.eq_rd]);
      next_st.eq_rd = (st.eq_rd == 5'(isrc_pkg::ERR_DEPTH - 1)) ?
                      5'h00 : st.eq_rd + 5'h01;
      next_st.eq_cnt = next_st.eq_cnt - 5'h01;
    end
    if (mem_wr) next_st.rdg_cnt = st.rdg_cnt + 11'h001;
    if (rdg_go && st.trig != isrc_pkg::TRIG_WAIT_MEM) begin
      push      = 1'b1;
      push_data = i_rdg_data;
    end
    if (i_meas_done) next_st.trig = isrc_pkg::TRIG_IDLE;
    if (st.fetching && fifo_ready) begin
      push      = 1'b1;
      push_data = rdg_mem[st.fetch_ptr];
      next_st.fetch_ptr = st.fetch_ptr + 11'h001;
      if (st.fetch_ptr + 11'h001 >= st.rdg_cnt) next_st.fetching = 1'b0;
    end
    if (cmd_go) begin
      case (i_cmd.op)
        isrc_pkg::C_CLS: begin
          next_st.esr = 8'h00;
          next_st.qev = 16'h0000;
        end
        isrc_pkg::C_ESE_W:  next_st.ese = i_cmd.arg[7:0];
        isrc_pkg::C_SRE_W:  next_st.sre = i_cmd.arg[7:0];
        isrc_pkg::C_QEN_W:  next_st.qen = i_cmd.arg;
        isrc_pkg::C_PRESET: next_st.qen = 16'h0000;
        isrc_pkg::C_PSC_W:  next_st.psc = i_cmd.arg[0];
        isrc_pkg::C_ESE_Q:  push_data = 32'(st.ese);
        isrc_pkg::C_SRE_Q:  push_data = 32'(st.sre);
        isrc_pkg::C_ESR_Q: begin
          push_data = 32'(st.esr);
          next_st.esr = 8'h00;
        end
        isrc_pkg::C_QEN_Q:  push_data = 32'(st.qen);
        isrc_pkg::C_QEV_Q: begin
          push_data = 32'(st.qev);
          next_st.qev = 16'h0000;
        end
        isrc_pkg::C_PSC_Q:  push_data = 32'(st.psc);
        isrc_pkg::C_STB_Q:  push_data = 32'(stb);
        isrc_pkg::C_OPC:
          next_st.esr[isrc_pkg::ESR_OPC_BIT] = 1'b1;
        isrc_pkg::C_OPC_Q:  push_data = isrc_pkg::OPC_ANSWER;
        isrc_pkg::C_RST: begin
          next_st.remote  = 1'b0;
          next_st.feed    = 1'b1;
          next_st.id_sel  = isrc_pkg::select_default_id_string;
          next_st.txt_len = 5'h00;
          next_st.trig    = isrc_pkg::TRIG_IDLE;
        end
        isrc_pkg::C_LOCAL:   next_st.remote = 1'b0;
        isrc_pkg::C_REMOTE:  next_st.remote = 1'b1;
        isrc_pkg::C_TXT_CHAR:
          if (txt_wr) next_st.txt_len = st.txt_len + 5'h01;
        isrc_pkg::C_TXT_CLR: next_st.txt_len = 5'h00;
        isrc_pkg::C_TXT_Q:
          push_data = {19'h0, st.txt_len, txt_mem[i_cmd.arg[3:0]]};
        isrc_pkg::C_ID_DEF:
          next_st.id_sel = isrc_pkg::select_default_id_string;
        isrc_pkg::C_ID_COMPAT:
          next_st.id_sel = isrc_pkg::select_compatible_id_string;
        isrc_pkg::C_ID_CHAR: begin
          next_st.id_sel = isrc_pkg::set_custom_id_string;
          if (i_cmd.arg[8]) next_st.id_len = 6'h00;
          else if (id_wr) next_st.id_len = st.id_len + 6'h01;
        end
        isrc_pkg::C_IDN_Q:
          push_data = {16'h0, st.id_sel, st.id_len,
                       (i_cmd.arg[5:0] < 6'(isrc_pkg::ID_MAX)) ?
                       id_mem[i_cmd.arg[5:0]] : 8'h00};
        isrc_pkg::C_POINTS_Q: push_data = 32'(st.rdg_cnt);
        isrc_pkg::C_FETCH_Q:
          if (st.feed && st.rdg_cnt != '0) begin
            next_st.fetching  = 1'b1;
            next_st.fetch_ptr = 11'h000;
          end
        isrc_pkg::C_READ_Q: next_st.trig = isrc_pkg::TRIG_WAIT_OUT;
        isrc_pkg::C_INIT: begin
          next_st.trig    = st.feed ? isrc_pkg::TRIG_WAIT_MEM :
                                      isrc_pkg::TRIG_WAIT_OUT;
          next_st.rdg_cnt = 11'h000;
        end
        isrc_pkg::C_FEED_W: next_st.feed = i_cmd.arg[0];
        default: ;
      endcase
      case (i_cmd.op)
        isrc_pkg::C_ESE_Q, isrc_pkg::C_SRE_Q, isrc_pkg::C_ESR_Q,
        isrc_pkg::C_QEN_Q, isrc_pkg::C_QEV_Q, isrc_pkg::C_PSC_Q,
        isrc_pkg::C_STB_Q, isrc_pkg::C_OPC_Q, isrc_pkg::C_ERR_Q,
        isrc_pkg::C_TXT_Q, isrc_pkg::C_IDN_Q, isrc_pkg::C_POINTS_Q:
          push = 1'b1;
        default: ;
      endcase
    end
    // hardware events win over a clear in the same cycle
    next_st.esr = next_st.esr | i_esr_event;
    next_st.qev = next_st.qev | i_ques_event;
    if (dev_clr) begin
      next_st.trig     = isrc_pkg::TRIG_IDLE;
      next_st.fetching = 1'b0;
      next_st.abort    = 1'b1;
      next_st.dtr      = 1'b1;
      push             = 1'b0;
    end else if (!fifo_ready) begin
      next_st.dtr = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st      <= '0;
      st.init <= 1'b1;
      st.feed <= 1'b1;
      st.dtr  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // arrays unreset; the counts bound their valid spans
  always_ff @(posedge i_core_clk) begin
    if (mem_wr) rdg_mem[st.rdg_cnt] <= i_rdg_data;
    if (eq_push) begin
      if (st.eq_cnt != 5'(isrc_pkg::ERR_DEPTH)) err_mem[st.eq_wr] <= eq_code;
      else if (!eq_pop)
        err_mem[(st.eq_wr == 5'h00) ? 5'(isrc_pkg::ERR_DEPTH - 1) :
                st.eq_wr - 5'h01] <= eq_code;
    end
    if (txt_wr) txt_mem[st.txt_len[3:0]] <= i_cmd.arg[7:0];
    if (id_wr && !i_cmd.arg[8]) id_mem[st.id_len] <= i_cmd.arg[7:0];
  end

  isrc_fifo #(
    .W     (32),
    .DEPTH (isrc_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_flush    (dev_clr),
    .i_valid    (push),
    .i_data     (push_data),
    .o_ready    (fifo_ready),
    .o_valid    (o_resp_valid),
    .o_data     (o_resp_data),
    .i_ready    (i_resp_ready)
  );

  assign o_trig_state = st.trig;
  assign o_abort      = st.abort;
  assign o_in_flush   = st.abort;
  assign o_dtr        = st.dtr;
  assign o_psc        = st.psc;
  assign o_ese        = st.ese;
  assign o_sre        = st.sre;
  assign o_stb        = stb;
  assign o_srq        = rqs;
  assign o_remote     = st.remote;
  assign o_msg_len    = st.txt_len;
  assign o_id_sel     = st.id_sel;
  assign o_talk_only  = i_bus_addr == isrc_pkg::TALK_ONLY_ADDR;
  assign o_tx_serial  = o_talk_only && i_serial_sel && !st.remote;
endmodule
`default_nettype wire

// [verification/isrc_props.sv]
// port checker of the status and remote control core
`default_nettype none
module isrc_props (
  input wire logic        i_core_clk,
  input wire logic        i_resetn,
  input wire logic        i_cmd_valid,
  input wire logic [20:0] i_cmd,
  input wire logic        o_cmd_ready,
  input wire logic        o_resp_valid,
  input wire logic [31:0] o_resp_data,
  input wire logic        i_dev_clear,
  input wire logic        i_ser_valid,
  input wire logic [7:0]  i_ser_byte,
  input wire logic        o_abort,
  input wire logic        o_dtr,
  input wire logic [1:0]  o_trig_state,
  input wire logic        o_remote,
  input wire logic [7:0]  o_key_active,
  input wire logic [4:0]  i_bus_addr,
  input wire logic        i_serial_sel,
  input wire logic        o_talk_only,
  input wire logic        o_tx_serial,
  input wire logic [7:0]  o_stb,
  input wire logic [7:0]  o_sre,
  input wire logic        o_srq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  a_clear_abort_dtr: assert property (i_dev_clear |-> ##[1:2]
    (o_abort && o_dtr)) else $error("no abort or dtr after clear");
  a_ctrlc_abort: assert property (i_ser_valid &&
    i_ser_byte == isrc_pkg::CTRL_C |-> ##[1:2] o_abort)
    else $error("serial clear did not abort");
  a_clear_idle_flush: assert property (i_dev_clear |=>
    o_trig_state == isrc_pkg::TRIG_IDLE && !o_resp_valid)
    else $error("clear left trigger or answers");
  a_opc_answer: assert property (i_cmd_valid && o_cmd_ready &&
    i_cmd[20:16] == isrc_pkg::C_OPC_Q && !o_resp_valid |=>
    o_resp_valid && o_resp_data == isrc_pkg::OPC_ANSWER)
    else $error("completion answer wrong");
  a_remote_keys: assert property (o_remote |->
    o_key_active[7:1] == 7'h00) else $error("key live in remote");
  a_talk_only_addr: assert property (o_talk_only ==
    (i_bus_addr == isrc_pkg::TALK_ONLY_ADDR)) else $error("talk only");
  a_tx_serial_sel: assert property (o_tx_serial ==
    (o_talk_only && i_serial_sel && !o_remote)) else $error("serial tx");
  a_rqs_summary: assert property (o_srq == |(o_stb & o_sre & 8'hBF)
    && o_stb[6] == o_srq) else $error("service request wrong");
  c_clear: cover property (i_dev_clear ##2 o_abort);
  c_tx: cover property (o_tx_serial);
  c_srq: cover property (o_srq);
endmodule
bind isrc_top isrc_props u_props (.i_core_clk(i_core_clk),
  .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .o_cmd_ready(o_cmd_ready), .o_resp_valid(o_resp_valid),
  .o_resp_data(o_resp_data), .i_dev_clear(i_dev_clear),
  .i_ser_valid(i_ser_valid), .i_ser_byte(i_ser_byte), .o_abort(o_abort),
  .o_dtr(o_dtr), .o_trig_state(o_trig_state), .o_remote(o_remote),
  .o_key_active(o_key_active), .i_bus_addr(i_bus_addr),
  .i_serial_sel(i_serial_sel), .o_talk_only(o_talk_only),
  .o_tx_serial(o_tx_serial), .o_stb(o_stb), .o_sre(o_sre), .o_srq(o_srq));
`default_nettype wire

// [verification/isrc_host.sv]
// host model: pops answers, stalls at random or on hold
`default_nettype none
module isrc_host (
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  input  wire logic i_hold,
  output logic      o_resp_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn)
      o_resp_ready <= 1'b0;
    else
      o_resp_ready <= !i_hold && ($urandom_range(3) != 0);
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench of the status and remote control core
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rstn, cv, rdv, md, dc, sv, ev, ssel, hold, psc;
  logic        cr, rsv, rr, rdr, ab, fl, dtr, er, pso, srq, to, tx;
  logic        rem;
  logic [31:0] rdd, rsd, r, v;
  logic [15:0] ec, qe;
  logic [7:0]  sb, ee, ne, ns, eso, sro, stb, kp, ka;
  logic [4:0]  ba, ml;
  logic [20:0] cmd;
  logic [1:0]  ts, ids;
  logic [31:0] rx[$], rq[$];
  int          eq[$];
  int          failures, checks_done, n0;
  isrc_top dut (.i_core_clk(clk), .i_resetn(rstn), .i_cmd_valid(cv),
    .i_cmd(cmd), .o_cmd_ready(cr), .o_resp_valid(rsv), .o_resp_data(rsd),
    .i_resp_ready(rr), .i_rdg_valid(rdv), .i_rdg_data(rdd),
    .o_rdg_ready(rdr), .i_meas_done(md), .o_trig_state(ts), .o_abort(ab),
    .o_in_flush(fl), .i_dev_clear(dc), .i_ser_valid(sv), .i_ser_byte(sb),
    .o_dtr(dtr), .i_err_valid(ev), .i_err_code(ec), .o_err_ready(er),
    .i_esr_event(ee), .i_ques_event(qe), .i_nv_psc(psc), .i_nv_ese(ne),
    .i_nv_sre(ns), .o_psc(pso), .o_ese(eso), .o_sre(sro), .o_stb(stb),
    .o_srq(srq), .i_bus_addr(ba), .i_serial_sel(ssel), .o_talk_only(to),
    .o_tx_serial(tx), .o_remote(rem), .i_key_pin(kp), .o_key_active(ka),
    .o_msg_len(ml), .o_id_sel(ids));
  isrc_host u_host (.i_core_clk(clk), .i_resetn(rstn), .i_hold(hold),
    .o_resp_ready(rr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    if (rsv === 1'b1 && rr === 1'b1) rx.push_back(rsd);
  task chk(string s, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task tk(int c);
    repeat (c) @(posedge clk);
  endtask
  // one error, reading or command handshake
  task hs(int k, logic [31:0] d);
    int n;
    n = 0;
    case (k)
      0: begin ev <= 1'b1; ec <= d[15:0]; end
      1: begin rdv <= 1'b1; rdd <= d; end
      default: begin cv <= 1'b1; cmd <= d[20:0]; end
    endcase
    @(negedge clk);
    while ((k == 0 ? er : k == 1 ? rdr : cr) !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) chk("handshake", 0, 1);
    @(posedge clk);
    {ev, rdv, cv} <= 3'h0;
    @(posedge clk);
  endtask
  task send(isrc_pkg::isrc_cmd_e op, logic [15:0] a);
    hs(2, {11'h000, op, a});
  endtask
  task waitrx(int m);
    int n;
    n = 0;
    while (rx.size() < m && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask
  task qry(isrc_pkg::isrc_cmd_e op, output logic [31:0] a);
    int m;
    m = rx.size();
    send(op, 16'h0000);
    waitrx(m + 1);
    a = rx.size() > m ? rx[m] : 32'hXXXX_XXXX;
  endtask
  // error queue model: full queue marks newest as overflow
  task mpush(int c);
    if (eq.size() < isrc_pkg::ERR_DEPTH) eq.push_back(c);
    else eq[isrc_pkg::ERR_DEPTH-1] = isrc_pkg::ERR_OVERFLOW;
  endtask
  task rst(logic p);
    psc <= p;
    rstn <= 1'b0;
    tk(5);
    rstn <= 1'b1;
    tk(3);
    rx.delete();
  endtask
  task summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ~400 cycles expected; margin for slow answers
  initial begin
    #4_000_000;
    failures++;
    summarize();
  end
  initial begin
    {cv, rdv, md, dc, sv, ev, ssel, hold, psc, rstn} = '0;
    {cmd, rdd, ec, qe, sb, ee, kp} = '0;
    ba = 5'h05;
    void'($urandom(32'h5EB0));
    ne = 8'($urandom);
    ns = 8'($urandom);
    rst(1'b0);
    chk("ese_keep", eso, ne);
    chk("sre_keep", sro, ns);
    send(isrc_pkg::C_PSC_W, 16'h0001);
    rst(1'b1);
    chk("ese_clr", eso, 8'h00);
    qry(isrc_pkg::C_PSC_Q, r);
    chk("psc", r, 32'h1);
    $display("test power_on done");
    v = $urandom & 32'hFF;
    send(isrc_pkg::C_SRE_W, v[15:0]);
    qry(isrc_pkg::C_SRE_Q, r);
    chk("sre", r, v);
    v = $urandom & 32'hFFFF;
    send(isrc_pkg::C_QEN_W, v[15:0]);
    qry(isrc_pkg::C_QEN_Q, r);
    chk("qen", r, v);
    send(isrc_pkg::C_PRESET, 16'h0000);
    qry(isrc_pkg::C_QEN_Q, r);
    chk("preset", r, 32'h0);
    send(isrc_pkg::C_ESE_W, 16'h0001);
    qry(isrc_pkg::C_ESE_Q, r);
    chk("ese", r, 32'h1);
    send(isrc_pkg::C_SRE_W, 16'h0020);
    send(isrc_pkg::C_OPC, 16'h0000);
    qry(isrc_pkg::C_STB_Q, r);
    chk("stb", r[6:5], 2'h3);
    qry(isrc_pkg::C_STB_Q, r);
    chk("stb_rqs", r[6], 1'b1);
    qry(isrc_pkg::C_ESR_Q, r);
    chk("esr", r, 32'h1);
    send(isrc_pkg::C_QEN_W, 16'h0004);
    qe <= 16'h0004;
    tk(1);
    qe <= 16'h0000;
    tk(1);
    chk("ques_sum", stb[3], 1'b1);
    qry(isrc_pkg::C_QEV_Q, r);
    chk("qev", r, 32'h4);
    ee <= 8'h01;
    tk(1);
    ee <= 8'h00;
    send(isrc_pkg::C_CLS, 16'h0000);
    chk("cls", stb & 8'h28, 8'h00);
    qry(isrc_pkg::C_OPC_Q, r);
    chk("opc", r, isrc_pkg::OPC_ANSWER);
    $display("test status done");
    repeat (22) begin
      v = $urandom_range(16'hFFFF, 1);
      hs(0, v);
      mpush(v);
    end
    chk("eav", stb[2], 1'b1);
    send(isrc_pkg::C_RST, 16'h0000);
    dc <= 1'b1;
    tk(1);
    dc <= 1'b0;
    tk(3);
    chk("ese_kept", eso, 8'h01);
    repeat (21) begin
      qry(isrc_pkg::C_ERR_Q, r);
      chk("err", r, eq.size() != 0 ? eq.pop_front() : 0);
    end
    $display("test errors done");
    repeat (18) send(isrc_pkg::C_TXT_CHAR, 16'h0041);
    chk("msg_len", ml, 5'h10);
    send(isrc_pkg::C_TXT_CLR, 16'h0000);
    chk("msg_clr", ml, 5'h00);
    send(isrc_pkg::C_ID_CHAR, 16'h0100);
    repeat (41) send(isrc_pkg::C_ID_CHAR, 16'h0042);
    qry(isrc_pkg::C_IDN_Q, r);
    chk("id_len", r[15:8], 8'hA7);
    send(isrc_pkg::C_ID_COMPAT, 16'h0000);
    chk("id_compat", ids, 1);
    send(isrc_pkg::C_ID_DEF, 16'h0000);
    chk("id_def", ids, 0);
    $display("test text_id done");
    send(isrc_pkg::C_REMOTE, 16'h0000);
    kp <= 8'($urandom) | 8'h01;
    ssel <= 1'b1;
    ba <= isrc_pkg::TALK_ONLY_ADDR;
    tk(20);
    chk("keys", ka[7:1], 7'h00);
    chk("talk", to, 1'b1);
    chk("tx_remote", tx, 1'b0);
    send(isrc_pkg::C_LOCAL, 16'h0000);
    chk("tx_local", tx, 1'b1);
    n0 = rx.size();
    v = $urandom;
    hs(1, v);
    waitrx(n0 + 1);
    chk("talk_rdg", rx[n0], v);
    ba <= 5'($urandom_range(30));
    tk(2);
    chk("no_talk", to, 1'b0);
    $display("test panel done");
    send(isrc_pkg::C_FEED_W, 16'h0001);
    send(isrc_pkg::C_INIT, 16'h0000);
    chk("wait_mem", ts, isrc_pkg::TRIG_WAIT_MEM);
    repeat (5) begin
      v = $urandom;
      rq.push_back(v);
      hs(1, v);
    end
    md <= 1'b1;
    tk(1);
    md <= 1'b0;
    tk(2);
    qry(isrc_pkg::C_POINTS_Q, r);
    chk("points", r, 32'h5);
    n0 = rx.size();
    send(isrc_pkg::C_FETCH_Q, 16'h0000);
    waitrx(n0 + 5);
    foreach (rq[i]) chk("fetch", rx[n0+i], rq[i]);
    send(isrc_pkg::C_FEED_W, 16'h0000);
    send(isrc_pkg::C_FETCH_Q, 16'h0000);
    mpush(isrc_pkg::ERR_NO_STORE);
    qry(isrc_pkg::C_ERR_Q, r);
    chk("no_store", r, eq.pop_front());
    send(isrc_pkg::C_READ_Q, 16'h0000);
    chk("wait_out", ts, isrc_pkg::TRIG_WAIT_OUT);
    n0 = rx.size();
    v = $urandom;
    hs(1, v);
    waitrx(n0 + 1);
    chk("read_rdg", rx[n0], v);
    dc <= 1'b1;
    tk(1);
    dc <= 1'b0;
    tk(2);
    chk("clr_idle", ts, isrc_pkg::TRIG_IDLE);
    chk("clr_dtr", dtr, 1'b1);
    send(isrc_pkg::C_READ_Q, 16'h0000);
    sb <= isrc_pkg::CTRL_C;
    sv <= 1'b1;
    tk(1);
    sv <= 1'b0;
    tk(2);
    chk("ctrlc_idle", ts, isrc_pkg::TRIG_IDLE);
    $display("test readings done");
    hold <= 1'b1;
    tk(2);
    n0 = rx.size();
    repeat (isrc_pkg::FIFO_DEPTH) send(isrc_pkg::C_OPC_Q, 16'h0000);
    tk(1);
    chk("full_rdy", cr, 1'b0);
    chk("full_dtr", dtr, 1'b0);
    hold <= 1'b0;
    waitrx(n0 + isrc_pkg::FIFO_DEPTH);
    for (int i = 0; i < isrc_pkg::FIFO_DEPTH; i++)
      chk("drain", rx[n0+i], isrc_pkg::OPC_ANSWER);
    $display("test buffer done");
    summarize();
  end
endmodule
`default_nettype wire
